// ==== src/fsp_map.vh ====
// register offsets, field positions, reset values and timing counts of the pixel port
`ifndef FSP_MAP_VH
`define FSP_MAP_VH
`define FSP_ADDR_W 21
`define FSP_OFF_START 21'h000000
`define FSP_OFF_READY 21'h040000
`define FSP_OFF_SYSRDY 21'h080000
`define FSP_OFF_ILACE 21'h0C0000
`define FSP_OFF_EVMODE 21'h100000
`define FSP_OFF_OUTEN 21'h140000
`define FSP_OFF_STATUS 21'h180000
`define FSP_OFF_LINEW 21'h1C0000
`define FSP_START_RST 16'h0000
`define FSP_LINEW_RST 10'h0A0
`define FSP_BIT0 0
`define FSP_STAT_FAULT 0
`define FSP_STAT_HALT 1
`define FSP_STAT_SPDA 2
`define FSP_STAT_SPDB 3
`define FSP_STAT_LINKOK 4
`define FSP_STAT_FIELD 5
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2
`define FSP_VRAM_AW 9
`define FSP_LINK_WAIT_MS 100
`define FSP_CLK_MHZ 200
`endif

// ==== src/fsp_pixel_port.v ====
// frame store pixel port: address generator, pixel bus drivers, control registers
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "fsp_map.vh"
module fsp_pixel_port
#(
    parameter LINK_WAIT_CYC = `FSP_LINK_WAIT_MS * 1000 * `FSP_CLK_MHZ
)
(
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // axi4-lite write
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // processor side
    input wire proc_error_i,
    input wire halt_inspect_i,
    input wire vram_wr_en_i,
    input wire [8:0] vram_wr_addr_i,
    input wire [31:0] vram_wr_data_i,
    output reg proc_event_o,
    output reg link_speed0_fast_o,
    output reg link_speed123_fast_o,
    output reg links_ready_o,
    output reg proc_halted_o,
    // system pins
    input wire speed_strap_port0_i,
    input wire speed_strap_ports123_i,
    output reg fault_indicator_n_o,
    output reg fault_indicator_n_oe_o,
    // pixel bus
    input wire sequencing_clk_n_i,
    input wire gated_vram_clk_n_i,
    input wire advance_blank_n_i,
    input wire field_start_n_i,
    input wire second_field_n_i,
    output reg [31:0] pixel_bus_lines_o,
    output reg [31:0] pixel_bus_lines_oe_o,
    input wire system_sync_wire_i,
    output reg system_sync_wire_o,
    output reg system_sync_wire_oe_o
);
    // every asynchronous pin passes two flops before use
    reg [7:0] sync1_r;
    reg [7:0] sync2_r;
    reg [7:0] prev_r;
    wire [7:0] pins_w = {proc_error_i, system_sync_wire_i, second_field_n_i,
        field_start_n_i, advance_blank_n_i, gated_vram_clk_n_i, sequencing_clk_n_i,
        halt_inspect_i};
    wire seq_fall_w = prev_r[1] & ~sync2_r[1];
    wire ram_fall_w = prev_r[2] & ~sync2_r[2];
    wire blank_n_w = sync2_r[3];
    wire field_n_w = sync2_r[4];
    wire even_n_w = sync2_r[5];
    wire sysw_w = sync2_r[6];
    wire err_w = sync2_r[7];

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // idle levels: error rests low, so no false fault pulse follows reset
            sync1_r <= 8'h7F;
            sync2_r <= 8'h7F;
            prev_r <= 8'h7F;
        end
        else
        begin
            sync1_r <= pins_w;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // control registers
    reg [15:0] start_r;
    reg [9:0] linew_r;
    reg ready_r;
    reg ilace_r;
    reg evmode_r;
    reg outen_r;
    reg [31:0] wait_cnt_r;
    reg strap_a_r;
    reg strap_b_r;
    reg strap_taken_r;
    reg halt_r;

    reg [2:0] boot_s1_r;
    reg [2:0] boot_s2_r;

    // straps and halt get unreset flops: they must be seen while reset is still low
    always @(posedge clock_i)
    begin
        boot_s1_r <= {halt_inspect_i, speed_strap_ports123_i, speed_strap_port0_i};
        boot_s2_r <= boot_s1_r;
        if (!strap_taken_r)
        begin
            strap_a_r <= boot_s2_r[0];
            strap_b_r <= boot_s2_r[1];
            halt_r <= boot_s2_r[2];
        end
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strap_taken_r <= 1'b0;
            wait_cnt_r <= 32'h0;
            links_ready_o <= 1'b0;
            link_speed0_fast_o <= 1'b0;
            link_speed123_fast_o <= 1'b0;
            proc_halted_o <= 1'b0;
        end
        else
        begin
            strap_taken_r <= 1'b1;
            link_speed0_fast_o <= strap_a_r;
            link_speed123_fast_o <= strap_b_r;
            proc_halted_o <= halt_r & strap_taken_r;
            // links held off until the post-reset wait ends
            if (wait_cnt_r != LINK_WAIT_CYC[31:0])
                wait_cnt_r <= wait_cnt_r + 32'h1;
            links_ready_o <= (wait_cnt_r == LINK_WAIT_CYC[31:0]);
        end
    end

    // address generator; line stride lets interlace skip alternate lines
    reg [8:0] addr_r;
    reg [8:0] line_base_r;
    reg [9:0] col_r;
    reg active_r;
    reg fetch_r;
    reg field_seen_r;
    wire [31:0] vram_q_w;

    function [8:0] fsp_word;
        input [15:0] base;
        begin
            fsp_word = base[8:0];
        end
    endfunction

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_r <= 9'h0;
            line_base_r <= 9'h0;
            col_r <= 10'h0;
            active_r <= 1'b0;
            fetch_r <= 1'b0;
            field_seen_r <= 1'b0;
        end
        else
        begin
            fetch_r <= 1'b0;
            if (!field_n_w)
            begin
                // field reset; odd field of an interlace pair starts one line in
                line_base_r <= fsp_word(start_r) + ((ilace_r && even_n_w) ?
                    linew_r[8:0] : 9'h0);
                addr_r <= fsp_word(start_r) + ((ilace_r && even_n_w) ?
                    linew_r[8:0] : 9'h0);
                col_r <= 10'h0;
                active_r <= 1'b0;
                field_seen_r <= ~even_n_w;
            end
            else
            begin
                active_r <= ~blank_n_w;
                if (active_r && ram_fall_w)
                begin
                    addr_r <= addr_r + 9'h1;
                    fetch_r <= 1'b1;
                    if (col_r == linew_r - 10'h1)
                    begin
                        col_r <= 10'h0;
                        // interlace skips the other field's line
                        line_base_r <= line_base_r + (ilace_r ?
                            {linew_r[7:0], 1'b0} : linew_r[8:0]);
                        addr_r <= line_base_r + (ilace_r ?
                            {linew_r[7:0], 1'b0} : linew_r[8:0]);
                    end
                    else
                        col_r <= col_r + 10'h1;
                end
            end
        end
    end

    fsp_vram u_vram
    (
        .clock_i(clock_i),
        .wr_en_i(vram_wr_en_i),
        .wr_addr_i(vram_wr_addr_i),
        .wr_data_i(vram_wr_data_i),
        .rd_addr_i(addr_r),
        .rd_data_o(vram_q_w)
    );

    // pixel bus lines move only on sequencing clock falling edges; sync wire, fault and event outputs follow every clock
    reg [31:0] pix_hold_r;
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pix_hold_r <= 32'h0;
            pixel_bus_lines_o <= 32'h0;
            pixel_bus_lines_oe_o <= 32'h0;
            system_sync_wire_o <= 1'b0;
            system_sync_wire_oe_o <= 1'b1;
            fault_indicator_n_o <= 1'b0;
            fault_indicator_n_oe_o <= 1'b0;
            proc_event_o <= 1'b0;
        end
        else
        begin
            if (fetch_r)
                pix_hold_r <= vram_q_w;
            if (seq_fall_w)
            begin
                // inverted open collector: a one bit pulls its line low
                pixel_bus_lines_o <= 32'h0;
                pixel_bus_lines_oe_o <= (outen_r && active_r) ?
                    pix_hold_r : 32'h0;
            end
            system_sync_wire_o <= 1'b0;
            system_sync_wire_oe_o <= ~ready_r;
            fault_indicator_n_o <= 1'b0;
            fault_indicator_n_oe_o <= err_w;
            proc_event_o <= evmode_r ? sysw_w : ~field_n_w;
        end
    end

    // axi4-lite slave: address and data taken in either order, answer two cycles after the later is taken
    reg aw_have_r;
    reg w_have_r;
    reg [20:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire wr_go_w = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire wen_w = wr_go_w & w_strb_r[0];

    function fsp_is;
        input [20:0] a;
        input [20:0] off;
        begin
            fsp_is = (a[20:2] == off[20:2]);
        end
    endfunction

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 21'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FSP_RESP_OKAY;
            start_r <= `FSP_START_RST;
            linew_r <= `FSP_LINEW_RST;
            ready_r <= 1'b0;
            ilace_r <= 1'b0;
            evmode_r <= 1'b0;
            outen_r <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr[20:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go_w)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // only the held low address bits decide; the live bus may have moved on
                s_axi_bresp <= (aw_addr_r <= `FSP_OFF_LINEW) ? `FSP_RESP_OKAY :
                    `FSP_RESP_SLVERR;
            end
            if (wen_w && fsp_is(aw_addr_r, `FSP_OFF_START))
                start_r <= w_data_r[31:16]; // buffers lie on 64 kbyte boundaries
            if (wen_w && fsp_is(aw_addr_r, `FSP_OFF_READY))
                ready_r <= w_data_r[`FSP_BIT0];
            if (wen_w && fsp_is(aw_addr_r, `FSP_OFF_ILACE))
                ilace_r <= w_data_r[`FSP_BIT0];
            if (wen_w && fsp_is(aw_addr_r, `FSP_OFF_EVMODE))
                evmode_r <= w_data_r[`FSP_BIT0];
            if (wen_w && fsp_is(aw_addr_r, `FSP_OFF_OUTEN))
                outen_r <= w_data_r[`FSP_BIT0];
            if (wen_w && fsp_is(aw_addr_r, `FSP_OFF_LINEW) && w_data_r[9:0] != 10'h0)
                linew_r <= w_data_r[9:0];
        end
    end

    // reads: one cycle from address taken to rvalid
    reg [31:0] rd_nxt;
    reg rd_ok_nxt;
    always @*
    begin
        rd_nxt = 32'h0;
        rd_ok_nxt = 1'b1;
        if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_START))
            rd_nxt = 32'h0;
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_READY))
            rd_nxt = {31'h0, ready_r};
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_SYSRDY))
            rd_nxt = {31'h0, sysw_w};
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_ILACE))
            rd_nxt = {31'h0, ilace_r};
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_EVMODE))
            rd_nxt = {31'h0, evmode_r};
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_OUTEN))
            rd_nxt = {31'h0, outen_r};
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_STATUS))
            rd_nxt = {26'h0, field_seen_r, links_ready_o, link_speed123_fast_o,
                link_speed0_fast_o, proc_halted_o, err_w};
        else if (fsp_is(s_axi_araddr[20:0], `FSP_OFF_LINEW))
            rd_nxt = {22'h0, linew_r};
        else
            rd_ok_nxt = 1'b0;
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FSP_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rd_ok_nxt ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
            end
            else if (s_axi_rready && s_axi_rvalid)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // fsp_pixel_port

// ==== src/fsp_vram.v ====
// dual-port display word store with registered read data
`timescale 1ns/10ps
module fsp_vram
(
    // clock
    input wire clock_i,
    // write port
    input wire wr_en_i,
    input wire [8:0] wr_addr_i,
    input wire [31:0] wr_data_i,
    // read port
    input wire [8:0] rd_addr_i,
    output reg [31:0] rd_data_o
);
    reg [31:0] mem_r [0:511];

    always @(posedge clock_i)
    begin
        if (wr_en_i)
            mem_r[wr_addr_i] <= wr_data_i;
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule // fsp_vram

// ==== verif/fsp_disp_drv.sv ====
// display driver model: sequencing clock, gated ram clock, field timing
`timescale 1ns/10ps
module fsp_disp_drv
#(
    parameter ACT = 8,
    parameter BLK = 6,
    parameter LINES = 3,
    parameter FLY = 4
)
(
    // pixel bus timing
    output reg seq_clk_n_o,
    output wire ram_clk_n_o,
    output reg adv_blank_n_o,
    output reg field_start_n_o,
    output reg second_field_n_o
);
    localparam FLEN = FLY + LINES * (ACT + BLK);
    integer pos_r;
    reg [1:0] blank_dly_r;
    // free running, flyback included
    initial
    begin
        {seq_clk_n_o, adv_blank_n_o, field_start_n_o, second_field_n_o, blank_dly_r} = 6'h3B;
        pos_r = 0;
        forever #24 seq_clk_n_o = ~seq_clk_n_o;
    end
    always @(negedge seq_clk_n_o)
    begin
        pos_r <= (pos_r == FLEN - 1) ? 0 : pos_r + 1;
        field_start_n_o <= pos_r >= FLY;
        adv_blank_n_o <= !(pos_r >= FLY && (pos_r - FLY) % (ACT + BLK) < ACT);
        if (pos_r == FLEN - 1)
            second_field_n_o <= ~second_field_n_o;
    end
    // real blanking trails the warning; it moves while the clock is high, so no glitch
    always @(posedge seq_clk_n_o)
        blank_dly_r <= {blank_dly_r[0], adv_blank_n_o};
    assign ram_clk_n_o = seq_clk_n_o | blank_dly_r[1];
endmodule // fsp_disp_drv

// ==== verif/fsp_pixel_port_sva.sv ====
// concurrent checks on the pixel port pins
`timescale 1ns/10ps
module fsp_pixel_port_sva
#(
    parameter LINK_WAIT_CYC = 50
)
(
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // watched pins
    input wire proc_error_i,
    input wire speed_strap_port0_i,
    input wire speed_strap_ports123_i,
    input wire link_speed0_fast_o,
    input wire link_speed123_fast_o,
    input wire links_ready_o,
    input wire fault_indicator_n_o,
    input wire fault_indicator_n_oe_o,
    input wire sequencing_clk_n_i,
    input wire advance_blank_n_i,
    input wire system_sync_wire_o,
    input wire [31:0] pixel_bus_lines_o,
    input wire [31:0] pixel_bus_lines_oe_o
);
    reg seq_d_r;
    reg [7:0] fall_age_r;
    reg [7:0] blank_cnt_r;
    integer up_cnt_r;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ages count from our own sample of the fall; the design adds its synchroniser lag
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seq_d_r <= 1'b1;
            fall_age_r <= 8'hFF;
            blank_cnt_r <= 8'h00;
            up_cnt_r <= 0;
        end
        else
        begin
            seq_d_r <= sequencing_clk_n_i;
            fall_age_r <= (seq_d_r && !sequencing_clk_n_i) ? 8'h00 :
                fall_age_r + {7'h00, fall_age_r != 8'hFF};
            blank_cnt_r <= !advance_blank_n_i ? 8'h00 :
                blank_cnt_r + {7'h00, blank_cnt_r != 8'hFF};
            up_cnt_r <= up_cnt_r + (up_cnt_r < LINK_WAIT_CYC + 10);
        end
    end
    a_strap_follow:
        assert property ($stable({speed_strap_port0_i, speed_strap_ports123_i}) [*5] |->
            link_speed0_fast_o == speed_strap_port0_i &&
            link_speed123_fast_o == speed_strap_ports123_i)
        else $error("link speed differs from strap");
    a_links_early:
        assert property (up_cnt_r < LINK_WAIT_CYC - 2 |-> !links_ready_o)
        else $error("links ready too soon");
    a_links_late:
        assert property (up_cnt_r > LINK_WAIT_CYC + 4 |-> links_ready_o)
        else $error("links ready too late");
    a_fault_pull:
        assert property (proc_error_i [*5] |-> fault_indicator_n_oe_o)
        else $error("fault line not pulled");
    a_fault_free:
        assert property (!proc_error_i [*5] |-> !fault_indicator_n_oe_o)
        else $error("fault line pulled without error");
    a_open_drain:
        assert property (pixel_bus_lines_o == 32'h0 && !system_sync_wire_o && !fault_indicator_n_o)
        else $error("open collector pin driven high");
    a_pixel_on_fall:
        assert property ($changed(pixel_bus_lines_oe_o) |-> fall_age_r <= 8'h06)
        else $error("pixel lines moved off the falling edge");
    a_blank_quiet:
        assert property (blank_cnt_r > 8'h18 |-> pixel_bus_lines_oe_o == 32'h0)
        else $error("pixel data during blanking");
endmodule // fsp_pixel_port_sva

bind fsp_pixel_port fsp_pixel_port_sva #(.LINK_WAIT_CYC(LINK_WAIT_CYC)) u_sva
(
    .clock_i(clock_i), .rst_n_i(rst_n_i), .proc_error_i(proc_error_i),
    .speed_strap_port0_i(speed_strap_port0_i), .speed_strap_ports123_i(speed_strap_ports123_i),
    .link_speed0_fast_o(link_speed0_fast_o), .link_speed123_fast_o(link_speed123_fast_o),
    .links_ready_o(links_ready_o), .fault_indicator_n_o(fault_indicator_n_o),
    .fault_indicator_n_oe_o(fault_indicator_n_oe_o), .sequencing_clk_n_i(sequencing_clk_n_i),
    .advance_blank_n_i(advance_blank_n_i), .system_sync_wire_o(system_sync_wire_o),
    .pixel_bus_lines_o(pixel_bus_lines_o), .pixel_bus_lines_oe_o(pixel_bus_lines_oe_o)
);

// ==== verif/testbench.sv ====
// self-checking bench for the frame store pixel port
`timescale 1ns/10ps
`include "fsp_map.vh"
module testbench;
    reg clock_i, rst_n_i, aw_v, w_v, ar_v, err_r, halt_r, we_r, sp0_r, sp1_r, peer_r;
    reg [31:0] axi_a, axi_d, wd_r, rd_r, v;
    reg [8:0] wa_r;
    reg [1:0] rs_r;
    wire awrdy, wrdy, bval, arrdy, rval, ev, f0, f1, lrdy, hlt, f_o, f_oe;
    wire seq_n, ram_n, blk_n, fs_n, sf_n, sy_o, sy_oe;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, px_o, px_oe;
    wire sync_w = (sy_oe ? sy_o : 1'b1) & ~peer_r;
    wire fault_w = f_oe ? f_o : 1'b1;
    wire [31:0] pix = ~((px_oe & px_o) | ~px_oe);
    reg [31:0] mem [0:511];
    reg [31:0] q [0:39];
    integer seed, miscompares, checks_done, i, n;
    fsp_pixel_port #(.LINK_WAIT_CYC(50)) dut
    (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .s_axi_awaddr(axi_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(awrdy), .s_axi_wdata(axi_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bval), .s_axi_bready(1'b1),
        .s_axi_araddr(axi_a), .s_axi_arvalid(ar_v), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rval), .s_axi_rready(1'b1), .proc_error_i(err_r),
        .halt_inspect_i(halt_r), .vram_wr_en_i(we_r), .vram_wr_addr_i(wa_r),
        .vram_wr_data_i(wd_r), .proc_event_o(ev), .link_speed0_fast_o(f0),
        .link_speed123_fast_o(f1), .links_ready_o(lrdy), .proc_halted_o(hlt),
        .speed_strap_port0_i(sp0_r), .speed_strap_ports123_i(sp1_r), .fault_indicator_n_o(f_o),
        .fault_indicator_n_oe_o(f_oe), .sequencing_clk_n_i(seq_n), .gated_vram_clk_n_i(ram_n),
        .advance_blank_n_i(blk_n), .field_start_n_i(fs_n), .second_field_n_i(sf_n),
        .pixel_bus_lines_o(px_o), .pixel_bus_lines_oe_o(px_oe), .system_sync_wire_i(sync_w),
        .system_sync_wire_o(sy_o), .system_sync_wire_oe_o(sy_oe)
    );
    fsp_disp_drv drv (.seq_clk_n_o(seq_n), .ram_clk_n_o(ram_n), .adv_blank_n_o(blk_n),
        .field_start_n_o(fs_n), .second_field_n_o(sf_n));
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task chk(input [8*8:1] nm, input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("BAD %0s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task results;
    begin
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task step;
    begin
        n = n + 1;
        if (n > 2000)
        begin
            miscompares = miscompares + 1;
            results;
        end
    end
    endtask
    task tick(input integer c);
        repeat (c) @(posedge clock_i);
    endtask
    // bready and rready stay high, so each answer is taken on the edge it shows
    task axi(input wr, input [31:0] a, input [31:0] d);
    begin
        n = 0;
        @(posedge clock_i);
        axi_a <= a;
        axi_d <= d;
        {aw_v, w_v, ar_v} <= {wr, wr, !wr};
        @(posedge clock_i);
        while (bval !== 1'b1 && rval !== 1'b1)
        begin
            if (awrdy === 1'b1) aw_v <= 1'b0;
            if (wrdy === 1'b1) w_v <= 1'b0;
            if (arrdy === 1'b1) ar_v <= 1'b0;
            step;
            @(posedge clock_i);
        end
        rd_r = rdata;
        rs_r = wr ? bresp : rresp;
    end
    endtask
    task do_reset(input h);
    begin
        rst_n_i <= 1'b0;
        halt_r <= h;
        tick(8);
        rst_n_i <= 1'b1;
        tick(4);
        halt_r <= 1'b0;
    end
    endtask
    // waits for a fresh fall of field start in the wanted field
    task await_field(input odd);
    begin
        n = 0;
        while (fs_n !== 1'b1)
        begin
            @(negedge seq_n);
            step;
        end
        while (fs_n !== 1'b0 || sf_n !== odd)
        begin
            @(negedge seq_n);
            step;
        end
    end
    endtask
    // waits for the wanted field, then finds the start word and its successors
    task capture(input [8:0] idx, input odd);
        integer k, hit;
    begin
        await_field(odd);
        for (k = 0; k < 40; k = k + 1)
        begin
            @(negedge seq_n);
            q[k] = pix;
        end
        hit = 38;
        for (k = 37; k >= 0; k = k - 1)
            if (q[k] === mem[idx]) hit = k;
        chk("start", hit < 38, 1);
        chk("next", q[hit + 1], mem[idx + 9'h001]);
        chk("third", q[hit + 2], mem[idx + 9'h002]);
    end
    endtask
    function [31:0] reg_at(input integer k);
        reg_at = k == 0 ? `FSP_OFF_READY : k == 1 ? `FSP_OFF_ILACE :
            k == 2 ? `FSP_OFF_EVMODE : `FSP_OFF_OUTEN;
    endfunction
    initial
    begin
        seed = 32'h3abae666;
        {miscompares, checks_done, n} = 96'h0;
        {rst_n_i, aw_v, w_v, ar_v, err_r, halt_r, we_r, sp0_r, sp1_r, peer_r} = 10'h000;
        {axi_a, axi_d, wd_r, wa_r} = 105'h0;
        do_reset(1'b0);
        chk("sync oe", sy_oe, 1);
        tick(15);
        chk("links", lrdy, 0);
        tick(50);
        chk("links", lrdy, 1);
        for (i = 0; i < 4; i = i + 1)
        begin
            {sp0_r, sp1_r} <= i[1:0];
            do_reset(1'b0);
            chk("speeds", {f0, f1}, i);
        end
        err_r <= 1'b1;
        tick(6);
        chk("fault", fault_w, 0);
        axi(1'b0, `FSP_OFF_STATUS, 0);
        chk("status", rd_r[0], 1);
        err_r <= 1'b0;
        tick(6);
        chk("fault", fault_w, 1);
        for (i = 0; i < 16; i = i + 1)
        begin
            v = $random(seed) & 32'h1;
            axi(1'b1, reg_at(i % 4), v);
            axi(1'b0, reg_at(i % 4), 0);
            chk("reg", rd_r, v);
        end
        axi(1'b0, `FSP_OFF_LINEW + 4, 0);
        chk("resp", rs_r, `FSP_RESP_SLVERR);
        axi(1'b0, `FSP_OFF_START, 0);
        chk("start rd", rd_r, 0);
        axi(1'b1, `FSP_OFF_READY, 1);
        axi(1'b1, `FSP_OFF_EVMODE, 1);
        for (i = 0; i < 2; i = i + 1)
        begin
            peer_r <= !i[0];
            tick(6);
            axi(1'b0, `FSP_OFF_SYSRDY, 0);
            chk("sysrdy", rd_r, i);
            chk("event", ev, i[0]);
        end
        axi(1'b1, `FSP_OFF_READY, 0);
        tick(6);
        chk("sync", sync_w, 0);
        axi(1'b1, `FSP_OFF_READY, 1);
        axi(1'b1, `FSP_OFF_EVMODE, 0);
        await_field(1'b1);
        tick(8);
        chk("event", ev, 1);
        for (i = 0; i < 512; i = i + 1)
        begin
            mem[i] = $random(seed);
            {we_r, wa_r, wd_r} <= {1'b1, i[8:0], mem[i]};
            tick(1);
        end
        we_r <= 1'b0;
        axi(1'b1, `FSP_OFF_START, 32'h00050000);
        axi(1'b1, `FSP_OFF_LINEW, 8);
        axi(1'b1, `FSP_OFF_OUTEN, 1);
        for (i = 0; i < 4; i = i + 1)
        begin
            axi(1'b1, `FSP_OFF_ILACE, i / 2);
            capture(i == 3 ? 9'h00D : 9'h005, i[0]);
        end
        axi(1'b1, `FSP_OFF_OUTEN, 0);
        tick(30);
        for (i = 0; i < 46; i = i + 1)
        begin
            @(negedge seq_n);
            chk("idle", px_oe, 0);
        end
        do_reset(1'b1);
        chk("halted", hlt, 1);
        do_reset(1'b0);
        chk("halted", hlt, 0);
        results;
    end
endmodule // testbench
